//--- design/fsts_pkg.sv
// Package with constants, types and helpers of the fuser temperature sequencer
// How it works
// - A lower converted sensor level means a hotter upper fusing roller.
// - Heater lamp output driven low heats; high keeps the heater off.
// - Heater switched on or off by comparing sensor level against current setpoint.
// - Level below over-temperature threshold forces heater off and flags an event.
// - Heating starts with lamp off and a pulse on the inrush-limit output.
// - After reset warm up until roughly 200 degrees, then leave warm-up.
// - First mode holds about 210 degrees for about five minutes.
// - Second mode lowers setpoint gradually to about 190 degrees over five minutes.
// - Third mode, preparing to print, holds about 190 degrees.
// - Idle holds a setpoint of 180 degrees.
// - Energy saving keeps the heater permanently off.
// - The 190 degree setpoint is selectable as 183 for export builds.
// - Printing setpoint: normal 190, thick paper 200, transparency film 180.
// - Count consecutive sheets up to 250 mm wide; throttle lengthens sheet spacing.
// - Throttle after 1000 narrow sheets in third mode, 30 in first or second.
// - Throttle released once the gap between prints exceeds 2 minutes.
package fsts_pkg;
  localparam int LVL_W = 10;
  localparam int TEMP_W = 8;
  localparam int CNT_W = 10;
  localparam int TMR_W = 19;
  localparam int TICK_W = 15;
  // Converter scale: level = LVL_AT_0C - LVL_PER_DEG * temperature
  localparam int LVL_AT_0C = 1000;
  localparam int LVL_PER_DEG = 4;
  localparam logic [LVL_W-1:0] HYST_BAND = 10'h004;
  // Temperatures in degrees Celsius
  localparam logic [TEMP_W-1:0] T_WARM = 8'hC8;      // 200
  localparam logic [TEMP_W-1:0] T_MODE1 = 8'hD2;     // 210
  localparam logic [TEMP_W-1:0] T_PRINT = 8'hBE;     // 190
  localparam logic [TEMP_W-1:0] T_PRINT_EXP = 8'hB7; // 183
  localparam logic [TEMP_W-1:0] T_THICK = 8'hC8;     // 200
  localparam logic [TEMP_W-1:0] T_FILM = 8'hB4;      // 180
  localparam logic [TEMP_W-1:0] T_IDLE = 8'hB4;      // 180
  localparam logic [TEMP_W-1:0] T_OVER = 8'hE6;      // 230
  // Times and counts
  localparam int CLK_FREQ_HZ = 25000000;
  localparam int TICK_TIME_US = 1000;
  localparam int TICK_CYC = TICK_TIME_US * (CLK_FREQ_HZ / 1000000);
  localparam int MODE1_TIME_S = 300;
  localparam int MODE2_TIME_S = 300;
  localparam int GAP_TIME_S = 120;
  localparam int INRUSH_TIME_MS = 100;
  localparam logic [TMR_W-1:0] INRUSH_TICKS = TMR_W'(INRUSH_TIME_MS * 1000 / TICK_TIME_US);
  localparam logic [9:0] NARROW_MAX_MM = 10'h0FA;    // 250 mm
  localparam logic [CNT_W-1:0] LIM_MODE3 = 10'h3E8;  // 1000 sheets
  localparam logic [CNT_W-1:0] LIM_MODE12 = 10'h01E; // 30 sheets
  localparam logic [LVL_W-1:0] LVL_RESET = 10'h3FF;

  typedef enum logic [2:0] {
    FSTS_WARM = 3'h0, FSTS_MODE1 = 3'h1, FSTS_MODE2 = 3'h2,
    FSTS_MODE3 = 3'h3, FSTS_IDLE = 3'h4, FSTS_SAVE = 3'h5
  } fsts_mode_t;

  typedef enum logic [1:0] {
    FSTS_H_OFF = 2'h0, FSTS_H_INRUSH = 2'h1, FSTS_H_ON = 2'h2
  } fsts_heat_t;

  typedef enum logic [1:0] {
    FSTS_PAPER_NORMAL = 2'h0, FSTS_PAPER_THICK = 2'h1, FSTS_PAPER_FILM = 2'h2
  } fsts_paper_t;

  // Mode requests from engine firmware, one-cycle pulses
  typedef struct packed {
    logic prepare;
    logic idle;
    logic save;
    logic wake;
  } fsts_req_t;

  // Status back to engine firmware
  typedef struct packed {
    fsts_mode_t mode;
    logic heating;
    logic over_temp;
  } fsts_stat_t;

  // Converts a temperature to the converter level it produces
  function automatic logic [LVL_W-1:0] temp_to_lvl(input logic [TEMP_W-1:0] t);
    int v;
    v = LVL_AT_0C - LVL_PER_DEG * int'(t);
    return LVL_W'(v);
  endfunction : temp_to_lvl
endpackage : fsts_pkg

//--- design/fsts_sync.sv
// Two-stage synchroniser for a bus of pin inputs
`timescale 1ns/10ps
module fsts_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] INIT = '0
) (
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic [W-1:0] din,
  output logic [W-1:0] dout
);
  logic [W-1:0] meta_ff;
  logic [W-1:0] sync_ff;

  // First stage feeds only the second stage
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      meta_ff <= INIT;
      sync_ff <= INIT;
    end else begin
      meta_ff <= din;
      sync_ff <= meta_ff;
    end
  end

  assign dout = sync_ff;
endmodule : fsts_sync

//--- design/fsts_hyst.sv
// On/off regulator with hysteresis around a setpoint level
`timescale 1ns/10ps
module fsts_hyst
  import fsts_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic [LVL_W-1:0] level,
  input wire logic [LVL_W-1:0] sp_level,
  output logic demand
);
  logic demand_ff;
  logic [LVL_W:0] hi_lim;
  logic [LVL_W:0] lo_lim;

  // Band edges, one bit wider so they cannot wrap
  assign hi_lim = {1'b0, sp_level} + {1'b0, HYST_BAND};
  assign lo_lim = (sp_level > HYST_BAND) ? {1'b0, sp_level - HYST_BAND} : '0;

  // Higher level is colder: heat above band, stop below band
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      demand_ff <= 1'b0;
    end else if ({1'b0, level} > hi_lim) begin
      demand_ff <= 1'b1;
    end else if ({1'b0, level} < lo_lim) begin
      demand_ff <= 1'b0;
    end
  end

  assign demand = demand_ff;
endmodule : fsts_hyst

//--- design/fsts_top.sv
// Fuser temperature sequencer: mode sequence, heater drive, inrush and page-rate throttle
`timescale 1ns/10ps
module fsts_top
  import fsts_pkg::*;
#(
  parameter int TICK_CYCLES = TICK_CYC,
  parameter int MODE1_TICKS = MODE1_TIME_S * (1000000 / TICK_TIME_US),
  parameter int STEP_TICKS = MODE2_TIME_S * (1000000 / TICK_TIME_US) / int'(T_MODE1 - T_PRINT),
  parameter int GAP_TICKS = GAP_TIME_S * (1000000 / TICK_TIME_US)
) (
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic [LVL_W-1:0] fuser_temp_sensor,
  input wire fsts_req_t req,
  input wire fsts_paper_t paper_type,
  input wire logic export_sel,
  input wire logic sheet_done,
  input wire logic [9:0] sheet_width_mm,
  output logic fuser_heater_lamp_b,
  output logic inrush_limit,
  output logic page_rate_throttle,
  output logic over_temp_ev,
  output fsts_stat_t stat
);
  logic [LVL_W-1:0] lvl_s;
  logic demand;
  logic [TICK_W-1:0] tick_cnt_ff;
  logic tick_ff;
  fsts_mode_t mode_ff;
  fsts_mode_t nxt_mode;
  logic [TMR_W-1:0] mode_tmr_ff;
  logic [TEMP_W-1:0] ramp_temp_ff;
  logic [TEMP_W-1:0] print_temp;
  logic [TEMP_W-1:0] sp_temp;
  logic [LVL_W-1:0] sp_level;
  logic over_temp;
  logic heat_req;
  fsts_heat_t heat_ff;
  fsts_heat_t nxt_heat;
  logic [TMR_W-1:0] inrush_tmr_ff;
  logic lamp_b_ff;
  logic inrush_ff;
  logic ot_q_ff;
  logic ot_ev_ff;
  logic [CNT_W-1:0] narrow_cnt_ff;
  logic throttle_ff;
  logic [TMR_W-1:0] gap_tmr_ff;
  logic gap_over;
  logic narrow;
  logic [CNT_W-1:0] base_cnt;
  logic [CNT_W-1:0] nxt_cnt;
  logic [CNT_W-1:0] limit;
  logic limit_en;
  fsts_stat_t stat_ff;

  // Converter level comes from pins, so it is synchronised first
  fsts_sync #(.W(LVL_W), .INIT(LVL_RESET)) u_lvl_sync (
    .sys_clk(sys_clk),
    .rst_b(rst_b),
    .din(fuser_temp_sensor),
    .dout(lvl_s)
  );

  // Hysteresis regulator against the current setpoint
  fsts_hyst u_hyst (
    .sys_clk(sys_clk),
    .rst_b(rst_b),
    .level(lvl_s),
    .sp_level(sp_level),
    .demand(demand)
  );

  // Millisecond time base for all long timers
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      tick_cnt_ff <= '0;
      tick_ff <= 1'b0;
    end else if (tick_cnt_ff == TICK_W'(TICK_CYCLES - 1)) begin
      tick_cnt_ff <= '0;
      tick_ff <= 1'b1;
    end else begin
      tick_cnt_ff <= tick_cnt_ff + 1'b1;
      tick_ff <= 1'b0;
    end
  end

  // Mode sequence; energy saving wins over other requests
  always_comb begin
    nxt_mode = mode_ff;
    unique case (mode_ff)
      FSTS_WARM: begin
        if (lvl_s <= temp_to_lvl(T_WARM)) begin
          nxt_mode = FSTS_MODE1;
        end
      end
      FSTS_MODE1: begin
        if (tick_ff && mode_tmr_ff >= TMR_W'(MODE1_TICKS - 1)) begin
          nxt_mode = FSTS_MODE2;
        end
      end
      FSTS_MODE2: begin
        if (tick_ff && ramp_temp_ff <= print_temp && mode_tmr_ff >= TMR_W'(STEP_TICKS - 1)) begin
          nxt_mode = FSTS_IDLE;
        end
      end
      FSTS_MODE3, FSTS_IDLE: begin
        nxt_mode = mode_ff;
      end
      FSTS_SAVE: begin
        if (req.wake) begin
          nxt_mode = FSTS_WARM;
        end
      end
      default: begin
        nxt_mode = FSTS_WARM;
      end
    endcase
    if (mode_ff != FSTS_SAVE && mode_ff != FSTS_WARM) begin
      if (req.prepare) begin
        nxt_mode = FSTS_MODE3;
      end else if (req.idle) begin
        nxt_mode = FSTS_IDLE;
      end
    end
    if (req.save) begin
      nxt_mode = FSTS_SAVE;
    end
  end

  // Mode register
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      mode_ff <= FSTS_WARM;
    end else begin
      mode_ff <= nxt_mode;
    end
  end

  // Mode timer: restarts on a mode change and on each ramp step
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      mode_tmr_ff <= '0;
    end else if (nxt_mode != mode_ff) begin
      mode_tmr_ff <= '0;
    end else if (tick_ff) begin
      if (mode_ff == FSTS_MODE2 && mode_tmr_ff >= TMR_W'(STEP_TICKS - 1)) begin
        mode_tmr_ff <= '0;
      end else if (mode_tmr_ff != {TMR_W{1'b1}}) begin
        mode_tmr_ff <= mode_tmr_ff + 1'b1;
      end
    end
  end

  // Ramp setpoint walks down one degree per step in the second mode
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      ramp_temp_ff <= T_MODE1;
    end else if (mode_ff != FSTS_MODE2) begin
      ramp_temp_ff <= T_MODE1;
    end else if (tick_ff && mode_tmr_ff >= TMR_W'(STEP_TICKS - 1) && ramp_temp_ff > print_temp) begin
      ramp_temp_ff <= ramp_temp_ff - 1'b1;
    end
  end

  // Setpoint selection per mode and paper type
  always_comb begin
    print_temp = export_sel ? T_PRINT_EXP : T_PRINT;
    sp_temp = T_IDLE;
    unique case (mode_ff)
      FSTS_WARM: sp_temp = T_WARM;
      FSTS_MODE1: sp_temp = T_MODE1;
      FSTS_MODE2: sp_temp = ramp_temp_ff;
      FSTS_MODE3: begin
        unique case (paper_type)
          FSTS_PAPER_THICK: sp_temp = T_THICK;
          FSTS_PAPER_FILM: sp_temp = T_FILM;
          default: sp_temp = print_temp;
        endcase
      end
      FSTS_IDLE: sp_temp = T_IDLE;
      FSTS_SAVE: sp_temp = T_IDLE;
      default: sp_temp = T_IDLE;
    endcase
  end

  assign sp_level = temp_to_lvl(sp_temp);
  assign over_temp = lvl_s < temp_to_lvl(T_OVER);
  assign heat_req = demand && !over_temp && mode_ff != FSTS_SAVE;

  // Heater phase: inrush pulse before full drive, dropped at once on no request
  always_comb begin
    nxt_heat = heat_ff;
    unique case (heat_ff)
      FSTS_H_OFF: begin
        if (heat_req) begin
          nxt_heat = FSTS_H_INRUSH;
        end
      end
      FSTS_H_INRUSH: begin
        if (!heat_req) begin
          nxt_heat = FSTS_H_OFF;
        end else if (tick_ff && inrush_tmr_ff >= INRUSH_TICKS - 1'b1) begin
          nxt_heat = FSTS_H_ON;
        end
      end
      FSTS_H_ON: begin
        if (!heat_req) begin
          nxt_heat = FSTS_H_OFF;
        end
      end
      default: begin
        nxt_heat = FSTS_H_OFF;
      end
    endcase
  end

  // Heater phase register and inrush timer
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      heat_ff <= FSTS_H_OFF;
      inrush_tmr_ff <= '0;
    end else begin
      heat_ff <= nxt_heat;
      if (nxt_heat != FSTS_H_INRUSH) begin
        inrush_tmr_ff <= '0;
      end else if (tick_ff) begin
        inrush_tmr_ff <= inrush_tmr_ff + 1'b1;
      end
    end
  end

  // Registered heater outputs: lamp low only in full drive
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      lamp_b_ff <= 1'b1;
      inrush_ff <= 1'b0;
    end else begin
      lamp_b_ff <= nxt_heat != FSTS_H_ON;
      inrush_ff <= nxt_heat == FSTS_H_INRUSH;
    end
  end

  // Over-temperature event pulse on entry
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      ot_q_ff <= 1'b0;
      ot_ev_ff <= 1'b0;
    end else begin
      ot_q_ff <= over_temp;
      ot_ev_ff <= over_temp && !ot_q_ff;
    end
  end

  // Narrow-sheet bookkeeping
  assign narrow = sheet_width_mm <= NARROW_MAX_MM;
  assign gap_over = gap_tmr_ff > TMR_W'(GAP_TICKS);
  assign base_cnt = gap_over ? '0 : narrow_cnt_ff;
  assign nxt_cnt = (base_cnt == {CNT_W{1'b1}}) ? base_cnt : base_cnt + 1'b1;
  assign limit_en = mode_ff == FSTS_MODE1 || mode_ff == FSTS_MODE2 || mode_ff == FSTS_MODE3;
  assign limit = (mode_ff == FSTS_MODE3) ? LIM_MODE3 : LIM_MODE12;

  // Gap timer since the last sheet, saturating past the limit
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      gap_tmr_ff <= '0;
    end else if (sheet_done) begin
      gap_tmr_ff <= '0;
    end else if (tick_ff && !gap_over) begin
      gap_tmr_ff <= gap_tmr_ff + 1'b1;
    end
  end

  // Sheet counter and throttle flag
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      narrow_cnt_ff <= '0;
      throttle_ff <= 1'b0;
    end else if (sheet_done) begin
      if (!narrow) begin
        narrow_cnt_ff <= '0;
        throttle_ff <= throttle_ff && !gap_over;
      end else begin
        narrow_cnt_ff <= nxt_cnt;
        throttle_ff <= (throttle_ff && !gap_over) || (limit_en && nxt_cnt >= limit);
      end
    end else if (gap_over) begin
      narrow_cnt_ff <= '0;
      throttle_ff <= 1'b0;
    end
  end

  // Status register
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      stat_ff <= '{mode: FSTS_WARM, heating: 1'b0, over_temp: 1'b0};
    end else begin
      stat_ff <= '{mode: nxt_mode, heating: nxt_heat == FSTS_H_ON, over_temp: over_temp};
    end
  end

  assign fuser_heater_lamp_b = lamp_b_ff;
  assign inrush_limit = inrush_ff;
  assign page_rate_throttle = throttle_ff;
  assign over_temp_ev = ot_ev_ff;
  assign stat = stat_ff;

  // Checks
  property p_ot_off;
    @(posedge sys_clk) disable iff (!rst_b) over_temp |=> fuser_heater_lamp_b && !inrush_limit;
  endproperty
  a_ot_off: assert property (p_ot_off) else $error("heater on during over-temperature");

  property p_ot_ev;
    @(posedge sys_clk) disable iff (!rst_b) over_temp && !ot_q_ff |=> over_temp_ev;
  endproperty
  a_ot_ev: assert property (p_ot_ev) else $error("over-temperature not flagged");

  property p_save_off;
    @(posedge sys_clk) disable iff (!rst_b) mode_ff == FSTS_SAVE |=> fuser_heater_lamp_b;
  endproperty
  a_save_off: assert property (p_save_off) else $error("heater on in energy saving");

  sequence s_heat_start;
    heat_ff == FSTS_H_OFF && heat_req;
  endsequence
  sequence s_inrush_out;
    inrush_limit && fuser_heater_lamp_b;
  endsequence
  property p_inrush;
    @(posedge sys_clk) disable iff (!rst_b) s_heat_start |=> s_inrush_out;
  endproperty
  a_inrush: assert property (p_inrush) else $error("heating began without inrush pulse");

  property p_lamp_excl;
    @(posedge sys_clk) disable iff (!rst_b) !fuser_heater_lamp_b |-> !inrush_limit && $past(heat_ff) != FSTS_H_OFF;
  endproperty
  a_lamp_excl: assert property (p_lamp_excl) else $error("lamp driven without inrush phase");

  property p_warm_exit;
    @(posedge sys_clk) disable iff (!rst_b) $rose(mode_ff == FSTS_MODE1) && $past(mode_ff) == FSTS_WARM
      |-> $past(lvl_s) <= temp_to_lvl(T_WARM);
  endproperty
  a_warm_exit: assert property (p_warm_exit) else $error("warm-up left before temperature");

  property p_idle_sp;
    @(posedge sys_clk) disable iff (!rst_b) mode_ff == FSTS_IDLE |-> sp_level == temp_to_lvl(T_IDLE);
  endproperty
  a_idle_sp: assert property (p_idle_sp) else $error("idle setpoint wrong");

  property p_gap_release;
    @(posedge sys_clk) disable iff (!rst_b) gap_over && !sheet_done |=> !page_rate_throttle && narrow_cnt_ff == '0;
  endproperty
  a_gap_release: assert property (p_gap_release) else $error("throttle held after long gap");

  property p_throttle_rise;
    @(posedge sys_clk) disable iff (!rst_b) $rose(page_rate_throttle) |-> $past(sheet_done) && narrow_cnt_ff >= $past(limit);
  endproperty
  a_throttle_rise: assert property (p_throttle_rise) else $error("throttle set below sheet limit");

  property p_wide_clear;
    @(posedge sys_clk) disable iff (!rst_b) sheet_done && !narrow |=> narrow_cnt_ff == '0;
  endproperty
  a_wide_clear: assert property (p_wide_clear) else $error("wide sheet did not clear count");
endmodule : fsts_top

//--- testbench/fsts_fuser_model.sv
// Behavioural fuser roller with thermistor converter and heater triac drives
`timescale 1ns/10ps
module fsts_fuser_model
  import fsts_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic fuser_heater_lamp_b,
  input wire logic inrush_limit,
  input wire logic ovr_en,
  input wire logic [LVL_W-1:0] ovr_lvl,
  output logic [LVL_W-1:0] fuser_temp_sensor,
  output int temp_c
);
  int rate;
  int acc_ff;
  int temp_ff;
  logic heat;
  // Full drive heats fast, the series resistor heats slowly, an idle lamp lets the roller cool
  always_comb begin
    heat = (fuser_heater_lamp_b === 1'b0) || (inrush_limit === 1'b1);
    rate = (fuser_heater_lamp_b === 1'b0) ? 2 : ((inrush_limit === 1'b1) ? 4 : 16);
  end
  // Roller temperature in whole degrees, never below room level
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      temp_ff <= 25;
      acc_ff <= 0;
    end else if (acc_ff + 1 >= rate) begin
      acc_ff <= 0;
      temp_ff <= heat ? temp_ff + 1 : ((temp_ff > 20) ? temp_ff - 1 : temp_ff);
    end else begin
      acc_ff <= acc_ff + 1;
    end
  end
  assign temp_c = temp_ff;
  // Converter: a hotter roller gives a lower level; the bench may override it
  assign fuser_temp_sensor = ovr_en ? ovr_lvl : LVL_W'(LVL_AT_0C - LVL_PER_DEG * temp_ff);
endmodule : fsts_fuser_model

//--- testbench/fsts_top_tb.sv
// Self-checking bench for the fuser temperature sequencer
`timescale 1ns/10ps
module fsts_top_tb
  import fsts_pkg::*;
;
  localparam int TK = 4;
  localparam int M1 = 150;
  localparam int ST = 3;
  localparam int GP = 30;
  logic sys_clk;
  logic rst_b;
  fsts_req_t req;
  fsts_paper_t paper_type;
  logic export_sel;
  logic sheet_done;
  logic [9:0] sheet_width_mm;
  logic ovr_en;
  logic [LVL_W-1:0] ovr_lvl;
  logic [LVL_W-1:0] fuser_temp_sensor;
  logic fuser_heater_lamp_b;
  logic inrush_limit;
  logic page_rate_throttle;
  logic over_temp_ev;
  fsts_stat_t stat;
  int temp_c;
  int n_errors = 0;
  int n_compared = 0;
  int cyc = 0;
  int t1;

  fsts_top #(.TICK_CYCLES(TK), .MODE1_TICKS(M1), .STEP_TICKS(ST), .GAP_TICKS(GP)) i_fsts_top (
    .sys_clk(sys_clk), .rst_b(rst_b), .fuser_temp_sensor(fuser_temp_sensor), .req(req),
    .paper_type(paper_type), .export_sel(export_sel), .sheet_done(sheet_done),
    .sheet_width_mm(sheet_width_mm), .fuser_heater_lamp_b(fuser_heater_lamp_b),
    .inrush_limit(inrush_limit), .page_rate_throttle(page_rate_throttle),
    .over_temp_ev(over_temp_ev), .stat(stat)
  );
  fsts_fuser_model i_fsts_fuser_model (
    .sys_clk(sys_clk), .rst_b(rst_b), .fuser_heater_lamp_b(fuser_heater_lamp_b),
    .inrush_limit(inrush_limit), .ovr_en(ovr_en), .ovr_lvl(ovr_lvl),
    .fuser_temp_sensor(fuser_temp_sensor), .temp_c(temp_c)
  );

  // Clock and free cycle count
  initial begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk) cyc <= cyc + 1;

  task automatic wrap_up();
    if (n_errors == 0 && n_compared > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : wrap_up

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_errors++;
      $display("CHECK FAILED at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask : check

  function automatic logic near(input int v, input int centre, input int tol);
    return (v >= centre - tol) && (v <= centre + tol);
  endfunction : near

  function automatic logic heat_on();
    return (fuser_heater_lamp_b === 1'b0) || (inrush_limit === 1'b1);
  endfunction : heat_on

  // Waits at falling edges for a mode, a missed bound ends the run
  task automatic wait_mode(input fsts_mode_t m, input int bound);
    int i;
    for (i = 0; i < bound && stat.mode !== m; i++) @(negedge sys_clk);
    if (stat.mode !== m) begin
      n_errors++;
      wrap_up();
    end
  endtask : wait_mode

  // One-cycle request, then a quiet cycle so back-to-back pulses never overlap
  task automatic pulse(input fsts_req_t r);
    req = r;
    @(negedge sys_clk);
    req = '0;
    @(negedge sys_clk);
  endtask : pulse

  task automatic sheet(input logic [9:0] w);
    sheet_width_mm = w;
    sheet_done = 1'b1;
    @(negedge sys_clk);
    sheet_done = 1'b0;
    @(negedge sys_clk);
  endtask : sheet

  // Drives the level to the colder side of a setpoint, onto it, to the hotter side, onto it again, and judges the heater demand
  task automatic check_sp(input int t);
    int lv;
    lv = LVL_AT_0C - LVL_PER_DEG * t;
    ovr_en = 1'b1;
    ovr_lvl = LVL_W'(lv + 8);
    repeat (8) @(negedge sys_clk);
    check(heat_on(), 1'b1);
    ovr_lvl = LVL_W'(lv);
    repeat (8) @(negedge sys_clk);
    check(heat_on(), 1'b1);
    ovr_lvl = LVL_W'(lv - 8);
    repeat (8) @(negedge sys_clk);
    check(heat_on(), 1'b0);
    check(fuser_heater_lamp_b, 1'b1);
    ovr_lvl = LVL_W'(lv);
    repeat (8) @(negedge sys_clk);
    check(heat_on(), 1'b0);
  endtask : check_sp

  // Warm-up from cold with the inrush pulse first
  task automatic t_warm();
    int i;
    check(stat.mode, FSTS_WARM);
    for (i = 0; i < 20 && inrush_limit !== 1'b1; i++) @(negedge sys_clk);
    check(inrush_limit, 1'b1);
    check(fuser_heater_lamp_b, 1'b1);
    for (i = 0; i < 1000 && inrush_limit === 1'b1; i++) @(negedge sys_clk);
    check(near(i, int'(INRUSH_TICKS) * TK, TK), 1'b1);
    @(negedge sys_clk);
    check(fuser_heater_lamp_b, 1'b0);
    check(stat.heating, 1'b1);
    wait_mode(FSTS_MODE1, 3000);
    t1 = cyc;
    check(near(temp_c, 201, 3), 1'b1);
  endtask : t_warm

  // Narrow sheets in the first mode, a wide one clearing the count, release after a gap
  task automatic t_thr12();
    int i;
    for (i = 0; i < 29; i++) sheet(10'h0FA);
    sheet(10'h0FB);
    for (i = 0; i < 29; i++) sheet(10'h0FA);
    check(page_rate_throttle, 1'b0);
    sheet(10'h0FA);
    check(page_rate_throttle, 1'b1);
    repeat (GP * TK - 8) @(negedge sys_clk);
    check(page_rate_throttle, 1'b1);
    repeat (3 * TK + 8) @(negedge sys_clk);
    check(page_rate_throttle, 1'b0);
  endtask : t_thr12

  // First mode length, stepped descent and second mode length
  task automatic t_seq();
    wait_mode(FSTS_MODE2, 1000);
    check(near(cyc - t1, M1 * TK, 2 * TK), 1'b1);
    t1 = cyc;
    repeat (120) @(negedge sys_clk);
    ovr_lvl = LVL_W'(LVL_AT_0C - LVL_PER_DEG * 195);
    repeat (8) @(negedge sys_clk);
    check(heat_on(), 1'b1);
    ovr_lvl = LVL_W'(LVL_AT_0C - LVL_PER_DEG * 205);
    repeat (8) @(negedge sys_clk);
    check(heat_on(), 1'b0);
    wait_mode(FSTS_IDLE, 1000);
    check(near(cyc - t1, (int'(T_MODE1) - int'(T_PRINT) + 1) * ST * TK, 2 * TK), 1'b1);
  endtask : t_seq

  // Idle setpoint, then print setpoints by paper type and export option
  task automatic t_paper();
    fsts_paper_t pt [4] = '{FSTS_PAPER_NORMAL, FSTS_PAPER_THICK, FSTS_PAPER_FILM, FSTS_PAPER_NORMAL};
    int tt [4] = '{190, 200, 180, 183};
    int i;
    check_sp(180);
    for (i = 0; i < 4; i++) begin
      paper_type = pt[i];
      export_sel = (i == 3);
      pulse('{prepare: 1'b1, idle: 1'b1, save: 1'b0, wake: 1'b0});
      check(stat.mode, FSTS_MODE3);
      check_sp(tt[i]);
      pulse('{prepare: 1'b0, idle: 1'b1, save: 1'b0, wake: 1'b0});
      check(stat.mode, FSTS_IDLE);
    end
    export_sel = 1'b0;
    pulse('{prepare: 1'b1, idle: 1'b0, save: 1'b0, wake: 1'b0});
  endtask : t_paper

  // Third mode needs a thousand narrow sheets
  task automatic t_thr3();
    int i;
    for (i = 0; i < 999; i++) sheet(10'h0C8);
    check(page_rate_throttle, 1'b0);
    sheet(10'h0FA);
    check(page_rate_throttle, 1'b1);
  endtask : t_thr3

  // Over-temperature while heating, then energy saving beating other requests
  task automatic t_over_save();
    int i;
    int ev;
    ovr_lvl = LVL_W'(LVL_AT_0C - LVL_PER_DEG * 150);
    repeat (8) @(negedge sys_clk);
    ovr_lvl = 10'h04F;
    ev = 0;
    for (i = 0; i < 10; i++) begin
      @(negedge sys_clk);
      ev += (over_temp_ev === 1'b1);
    end
    check(ev, 1);
    check(fuser_heater_lamp_b, 1'b1);
    check(inrush_limit, 1'b0);
    check(stat.over_temp, 1'b1);
    check(stat.heating, 1'b0);
    ovr_lvl = LVL_W'(LVL_AT_0C - LVL_PER_DEG * 150);
    pulse('{prepare: 1'b1, idle: 1'b1, save: 1'b1, wake: 1'b0});
    check(stat.mode, FSTS_SAVE);
    for (i = 0; i < 20; i++) begin
      @(negedge sys_clk);
      check(fuser_heater_lamp_b, 1'b1);
    end
    pulse('{prepare: 1'b0, idle: 1'b0, save: 1'b0, wake: 1'b1});
    check(stat.mode, FSTS_WARM);
  endtask : t_over_save

  // Hang guard
  initial begin
    #(40 * 100000);
    n_errors++;
    wrap_up();
  end

  initial begin
    rst_b = 1'b0;
    req = '0;
    paper_type = FSTS_PAPER_NORMAL;
    export_sel = 1'b0;
    sheet_done = 1'b0;
    sheet_width_mm = 10'h000;
    ovr_en = 1'b0;
    ovr_lvl = 10'h000;
    repeat (4) @(negedge sys_clk);
    check(fuser_heater_lamp_b, 1'b1);
    check(inrush_limit, 1'b0);
    check(page_rate_throttle, 1'b0);
    check(stat.mode, FSTS_WARM);
    rst_b = 1'b1;
    t_warm();
    check_sp(210);
    t_thr12();
    t_seq();
    t_paper();
    t_thr3();
    t_over_save();
    wrap_up();
  end
endmodule : fsts_top_tb
